//--- pwt_pkg.sv
// Functional notes
// - Count register is read/writable; writes land one cycle later (sync) or two (async).
// - Compare matches only when counting into a value, never from software writes.
// - Matches on compare A and B set their flags after one synchronising cycle.
// - With clear-on-top, top match clears count and sets overflow flag after sync delay.
// - PLL status bits 7..3 always read zero.
// - Fast clock select bit 2 picks fast tick source, else core clock.
// - Fast clock select can be set only while PLL start bit is set.
// - PLL start bit 1 starts PLL; reads one when PLL is system clock.
// - Lock indicator bit 0 sets after the worst-case lock time.
// - PWM mode gives dual 8-bit glitch-free generator with true and inverted outputs.
// - Pair outputs never high together; non-overlap one prescaled cycle.
// - Edges delayed one source clock; rising edges also one prescaled cycle.
// - PWM count runs 00 to top then restarts; top match sets overflow flag.
// - Mode 01: true clears on match, sets at 01; inverted sets after match, clears at 00.
// - Mode 00 disconnects pair; 10 true only; 11 true set after match, clear at 00.
// - PWM-mode compare writes go to holding register, moved in at top match.
// - Compare reads return the held value while a transfer is pending.
// - Compare at 00 or top holds outputs static per mode.
// - Flags set as in normal mode; interrupt needs flag, own enable, global enable.
// - PWM frequency is prescaled clock divided by top plus one.
// - PWM enable bits select PWM mode; count returns to 00 after top match.
// - Clock select 0 stops; codes 1..15 divide source by 1 to 16384.
package pwt_pkg;
   // ---------------------------------------------------------------
   // Register indexes (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [5:0] IDX_PLL_STATUS = 6'h29;
   localparam logic [5:0] IDX_TOP = 6'h2b;
   localparam logic [5:0] IDX_CMP_B = 6'h2c;
   localparam logic [5:0] IDX_CMP_A = 6'h2d;
   localparam logic [5:0] IDX_COUNT = 6'h2e;
   localparam logic [5:0] IDX_CTRL_B = 6'h2f;
   localparam logic [5:0] IDX_CTRL_A = 6'h30;
   localparam logic [5:0] IDX_FLAGS = 6'h38;
   localparam logic [5:0] IDX_INT_EN = 6'h39;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int POS_LOCK = 0;
   localparam int POS_PLL_START = 1;
   localparam int POS_FAST_SEL = 2;
   localparam int POS_PWM_B = 0;
   localparam int POS_PWM_A = 1;
   localparam int POS_MODE_B = 4;
   localparam int POS_MODE_A = 6;
   localparam int POS_CS = 0;
   localparam int POS_PSC_RST = 6;
   localparam int POS_CLR_TOP = 7;
   localparam int POS_OVF = 0;
   localparam int POS_CMP_B = 1;
   localparam int POS_CMP_A = 2;
   localparam int POS_GIE = 7;
   // ---------------------------------------------------------------
   // Reset values and encodings
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_TOP = 8'hff;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_PAIR = 2'h1;
   localparam logic [1:0] MODE_TRUE = 2'h2;
   localparam logic [1:0] MODE_INV = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] WR_DLY_SYNC = 2'h1;
   localparam logic [1:0] WR_DLY_ASYNC = 2'h2;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 25000;
   localparam int PLL_LOCK_US = 100;
   localparam int PLL_LOCK_CYCLES = (PLL_LOCK_US * 1000000) / CLK_PERIOD_PS;
   localparam logic [11:0] PLL_LOCK_CNT = 12'(PLL_LOCK_CYCLES);
   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic a_true;
      logic a_inv;
      logic b_true;
      logic b_inv;
   } pwt_pins_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } pwt_wreq_t;
endpackage

//--- pwt_switches.sv
`timescale 1ns/1ps
module pwt_switches (
   input wire logic clk_sys,
   input wire logic rst,
   input wire pwt_pkg::pwt_pins_t pin_level,
   input wire pwt_pkg::pwt_pins_t pin_oe,
   output pwt_pkg::pwt_pins_t gate,
   output logic shoot
);
   import pwt_pkg::*;
   // Gates sit on pull-downs, so a released pin turns its switch off
   assign gate = pwt_pins_t'(pin_level & pin_oe);
   // Sticky: one overlap is enough to ruin a half bridge
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst)
         shoot <= 1'b0;
      else if ((gate.a_true & gate.a_inv) | (gate.b_true & gate.b_inv))
         shoot <= 1'b1;
   end
endmodule

//--- pwt_timer.sv
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module pwt_timer (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic fast_clk_tick,
   input wire logic pll_sys_source,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output pwt_pkg::pwt_pins_t pin_level,
   output pwt_pkg::pwt_pins_t pin_oe,
   output logic irq_request
);
   import pwt_pkg::*;

   // ---------------------------------------------------------------
   // Bus slave
   // ---------------------------------------------------------------
   logic aw_full, w_full;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   pwt_wreq_t wreq;
   logic do_write, wr_hit;
   logic [5:0] wr_idx;
   logic [7:0] wr_byte;

   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready = !w_full && !s_axi_bvalid;
   assign do_write = aw_full && w_full && !s_axi_bvalid;
   assign wreq = '{addr: aw_addr, data: w_data, strb: w_strb};
   assign wr_idx = wreq.addr[7:2];
   assign wr_byte = wreq.data[7:0];

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_full <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_full <= 1'b0;
         end
      end
   end

   always_comb begin
      case (wr_idx)
         IDX_PLL_STATUS, IDX_TOP, IDX_CMP_B, IDX_CMP_A, IDX_COUNT,
         IDX_CTRL_B, IDX_CTRL_A, IDX_FLAGS, IDX_INT_EN: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Only the low byte lane carries register data
   function automatic logic wr_to(input logic [5:0] idx);
      wr_to = do_write && wr_idx == idx && wreq.strb[0];
   endfunction

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   logic [7:0] ctrl_a, int_en, top;
   logic [3:0] clk_sel;
   logic clear_top, pll_start, fast_sel, lock;
   logic [11:0] lock_cnt;
   logic pwm_any, pll_start_eff;
   logic [1:0] mode_a, mode_b;

   assign mode_a = ctrl_a[POS_MODE_A +: 2];
   assign mode_b = ctrl_a[POS_MODE_B +: 2];
   assign pwm_any = ctrl_a[POS_PWM_A] || ctrl_a[POS_PWM_B];
   assign pll_start_eff = pll_start || pll_sys_source;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_a <= RST_BYTE;
         int_en <= RST_BYTE;
         top <= RST_TOP;
         clk_sel <= 4'h0;
         clear_top <= 1'b0;
      end else begin
         if (wr_to(IDX_CTRL_A)) ctrl_a <= wr_byte;
         if (wr_to(IDX_INT_EN)) int_en <= wr_byte;
         if (wr_to(IDX_TOP)) top <= wr_byte;
         if (wr_to(IDX_CTRL_B)) begin
            clk_sel <= wr_byte[POS_CS +: 4];
            clear_top <= wr_byte[POS_CLR_TOP];
         end
      end
   end

   // ---------------------------------------------------------------
   // PLL start, lock and clock select
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pll_start <= 1'b0;
         fast_sel <= 1'b0;
      end else if (wr_to(IDX_PLL_STATUS)) begin
         pll_start <= wr_byte[POS_PLL_START];
         fast_sel <= wr_byte[POS_FAST_SEL] && (wr_byte[POS_PLL_START] || pll_sys_source);
      end else if (!pll_start_eff) begin
         fast_sel <= 1'b0;
      end
   end

   // Lock model counts the worst case so software never sees an early lock
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lock_cnt <= 12'h000;
         lock <= 1'b0;
      end else if (!pll_start_eff) begin
         lock_cnt <= 12'h000;
         lock <= 1'b0;
      end else if (lock_cnt == PLL_LOCK_CNT - 12'h001) begin
         lock <= 1'b1;
      end else begin
         lock_cnt <= lock_cnt + 12'h001;
      end
   end

   // ---------------------------------------------------------------
   // Prescaler
   // ---------------------------------------------------------------
   logic src_tick, tick;
   logic [13:0] presc, presc_mask;

   assign src_tick = fast_sel ? fast_clk_tick : 1'b1;
   assign presc_mask = (14'h0001 << (clk_sel - 4'h1)) - 14'h0001;
   assign tick = src_tick && clk_sel != 4'h0 && (presc & presc_mask) == presc_mask;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         presc <= 14'h0000;
      end else if (wr_to(IDX_CTRL_B) && wr_byte[POS_PSC_RST]) begin
         presc <= 14'h0000;
      end else if (src_tick) begin
         presc <= presc + 14'h0001;
      end
   end

   // ---------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------
   logic [7:0] cnt, next_cnt, wr_val;
   logic [1:0] wr_dly;
   logic wrap, top_hit, a_hit, b_hit, ovf_hit;
   logic [7:0] act_a, act_b, hold_a, hold_b;

   assign wrap = cnt == top && (clear_top || pwm_any);
   assign next_cnt = wrap ? 8'h00 : cnt + 8'h01;
   // Only counting steps compare, so software writes never match
   assign top_hit = tick && wr_dly != WR_DLY_SYNC && next_cnt == top;
   assign a_hit = tick && wr_dly != WR_DLY_SYNC && next_cnt == act_a;
   assign b_hit = tick && wr_dly != WR_DLY_SYNC && next_cnt == act_b;
   // Top only counts as overflow when it really ends the count
   assign ovf_hit = top_hit && (clear_top || pwm_any) || tick && wr_dly != WR_DLY_SYNC && cnt == 8'hff && !wrap;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_dly <= 2'h0;
         wr_val <= 8'h00;
      end else if (wr_to(IDX_COUNT)) begin
         wr_dly <= fast_sel ? WR_DLY_ASYNC : WR_DLY_SYNC;
         wr_val <= wr_byte;
      end else if (wr_dly != 2'h0) begin
         wr_dly <= wr_dly - 2'h1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt <= 8'h00;
      end else if (wr_dly == WR_DLY_SYNC) begin
         cnt <= wr_val;
      end else if (tick) begin
         cnt <= next_cnt;
      end
   end

   // ---------------------------------------------------------------
   // Compare values with PWM holding stage
   // ---------------------------------------------------------------
   logic pend_a, pend_b;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         act_a <= RST_BYTE;
         act_b <= RST_BYTE;
         hold_a <= RST_BYTE;
         hold_b <= RST_BYTE;
         pend_a <= 1'b0;
         pend_b <= 1'b0;
      end else begin
         if (wr_to(IDX_CMP_A)) begin
            hold_a <= wr_byte;
            pend_a <= pwm_any;
            if (!pwm_any) act_a <= wr_byte;
         end else if (pend_a && top_hit) begin
            act_a <= hold_a;
            pend_a <= 1'b0;
         end
         if (wr_to(IDX_CMP_B)) begin
            hold_b <= wr_byte;
            pend_b <= pwm_any;
            if (!pwm_any) act_b <= wr_byte;
         end else if (pend_b && top_hit) begin
            act_b <= hold_b;
            pend_b <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Flags and interrupt request
   // ---------------------------------------------------------------
   logic [2:0] match_q, flags;
   logic [2:0] flag_clr;

   assign flag_clr = wr_to(IDX_FLAGS) ? wr_byte[2:0] : 3'h0;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         match_q <= 3'h0;
         flags <= 3'h0;
      end else begin
         // One cycle of synchronisation before the flags see a match
         match_q <= {a_hit, b_hit, ovf_hit};
         flags <= (flags & ~flag_clr) | match_q;
      end
   end

   assign irq_request = int_en[POS_GIE] && |(flags & int_en[2:0]);

   // ---------------------------------------------------------------
   // PWM waveform and dead time
   // ---------------------------------------------------------------
   logic [1:0] pwm_en;
   logic [1:0] lvl_true, lvl_inv, out_true, out_inv, oe_true, oe_inv;
   logic [7:0] act_x [2];
   logic [1:0] mode_x [2];

   assign pwm_en = {ctrl_a[POS_PWM_A], ctrl_a[POS_PWM_B]};
   assign act_x[1] = act_a;
   assign act_x[0] = act_b;
   assign mode_x[1] = mode_a;
   assign mode_x[0] = mode_b;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         logic base, comp, q_true, q_inv;
         // Windows leave count==cmp and count==00 low on both: one prescaled gap
         always_comb begin
            if (act_x[ch] == 8'h00) begin
               base = 1'b0;
               comp = 1'b1;
            end else if (act_x[ch] == top) begin
               base = 1'b1;
               comp = 1'b0;
            end else begin
               base = cnt >= 8'h01 && cnt < act_x[ch];
               comp = cnt > act_x[ch];
            end
         end
         assign lvl_true[ch] = (mode_x[ch] == MODE_INV) ? comp : base;
         assign lvl_inv[ch] = comp;
         // Edges follow one source clock after the count moves
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               q_true <= 1'b0;
               q_inv <= 1'b0;
            end else if (!pwm_en[ch]) begin
               q_true <= 1'b0;
               q_inv <= 1'b0;
            end else if (src_tick) begin
               q_true <= lvl_true[ch];
               q_inv <= lvl_inv[ch];
            end
         end
         assign out_true[ch] = q_true;
         assign out_inv[ch] = q_inv;
         assign oe_true[ch] = pwm_en[ch] && mode_x[ch] != MODE_OFF;
         assign oe_inv[ch] = pwm_en[ch] && mode_x[ch] == MODE_PAIR;
      end
   endgenerate

   assign pin_level = '{a_true: out_true[1] && oe_true[1], a_inv: out_inv[1] && oe_inv[1],
                        b_true: out_true[0] && oe_true[0], b_inv: out_inv[0] && oe_inv[0]};
   assign pin_oe = '{a_true: oe_true[1], a_inv: oe_inv[1], b_true: oe_true[0], b_inv: oe_inv[0]};

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   logic [7:0] rd_byte;
   logic rd_hit;

   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      rd_hit = 1'b1;
      case (s_axi_araddr[7:2])
         IDX_PLL_STATUS: rd_byte = {5'h00, fast_sel, pll_start_eff, lock};
         IDX_TOP: rd_byte = top;
         IDX_CMP_B: rd_byte = pend_b ? hold_b : act_b;
         IDX_CMP_A: rd_byte = pend_a ? hold_a : act_a;
         IDX_COUNT: rd_byte = cnt;
         IDX_CTRL_B: rd_byte = {clear_top, 3'h0, clk_sel};
         IDX_CTRL_A: rd_byte = ctrl_a;
         IDX_FLAGS: rd_byte = {5'h00, flags};
         IDX_INT_EN: rd_byte = int_en;
         default: begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, rd_byte};
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_top_reached;
      top_hit && pwm_any && pend_a && !wr_to(IDX_CMP_A);
   endsequence

   sequence s_hold_moved;
      ##1 act_a == $past(hold_a);
   endsequence

   a_count_write_sync: assert property (@(posedge clk_sys) disable iff (rst)
      wr_to(IDX_COUNT) && !fast_sel |=> ##1 cnt == $past(wr_byte, 2))
      else $error("count write not applied after one cycle");
   a_count_write_async: assert property (@(posedge clk_sys) disable iff (rst)
      wr_to(IDX_COUNT) && fast_sel |=> ##2 cnt == $past(wr_byte, 3))
      else $error("count write not applied after two cycles");
   a_pair_no_overlap: assert property (@(posedge clk_sys) disable iff (rst)
      !(pin_level.a_true && pin_level.a_inv) && !(pin_level.b_true && pin_level.b_inv))
      else $error("complementary outputs high together");
   a_flag_a_delay: assert property (@(posedge clk_sys) disable iff (rst)
      a_hit |-> ##2 flags[POS_CMP_A])
      else $error("compare A flag not set two cycles after match");
   a_top_clears: assert property (@(posedge clk_sys) disable iff (rst)
      tick && cnt == top && clear_top && wr_dly != WR_DLY_SYNC |=> cnt == 8'h00)
      else $error("count not cleared at top");
   a_fast_needs_start: assert property (@(posedge clk_sys) disable iff (rst)
      fast_sel |-> pll_start_eff)
      else $error("fast select set without PLL start");
   a_lock_timing: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(lock) |-> lock_cnt == PLL_LOCK_CNT - 12'h001 && $past(pll_start_eff))
      else $error("lock indicator at wrong time");
   a_hold_transfer: assert property (@(posedge clk_sys) disable iff (rst)
      s_top_reached |-> s_hold_moved)
      else $error("held compare value not transferred at top");
   a_stop_code: assert property (@(posedge clk_sys) disable iff (rst)
      clk_sel == 4'h0 && wr_dly == 2'h0 |=> $stable(cnt))
      else $error("counter moved while stopped");
   a_static_zero: assert property (@(posedge clk_sys) disable iff (rst)
      pwm_en[1] && act_a == 8'h00 && src_tick |=> out_true[1] == $past(mode_a == MODE_INV) && out_inv[1])
      else $error("outputs not static at compare zero");
   a_irq_gate: assert property (@(posedge clk_sys) disable iff (rst)
      irq_request |-> int_en[POS_GIE] && (flags & int_en[2:0]) != 3'h0)
      else $error("interrupt without enabled flag");
endmodule

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
   import pwt_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, fast_clk_tick = 1'b0, pll_sys_source = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_request, shoot;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   pwt_pins_t pin_level, pin_oe, gate;
   int n_fail = 0, cmp_count = 0;
   always #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) fast_clk_tick <= ~fast_clk_tick;
   pwt_timer pwt_timer_i (.clk_sys, .rst, .fast_clk_tick, .pll_sys_source, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .pin_level, .pin_oe, .irq_request);
   pwt_switches pwt_switches_i (.clk_sys, .rst, .pin_level, .pin_oe, .gate, .shoot);
   // ---------------------------------------------------------------
   // Bus tasks
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      @(posedge clk_sys);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rdr(input logic [5:0] idx);
      @(posedge clk_sys);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_pll;
      int i;
      i = 0;
      rdr(IDX_PLL_STATUS);
      chk("pll reset", 32'h0, rd);
      wr(IDX_PLL_STATUS, 8'h04);
      rdr(IDX_PLL_STATUS);
      chk("fast sel alone", 32'h0, rd);
      wr(IDX_PLL_STATUS, 8'h02);
      // Polling is the only safe way to learn the lock moment
      do begin
         rdr(IDX_PLL_STATUS);
         i++;
      end while (rd[0] !== 1'b1 && i < 3000);
      chk("locked", 32'h3, rd);
      chk("lock wait", 32'h1, {31'h0, i > 500});
      wr(IDX_PLL_STATUS, 8'hfe);
      rdr(IDX_PLL_STATUS);
      chk("status", 32'h7, rd);
      wr(IDX_PLL_STATUS, 8'h00);
      rdr(IDX_PLL_STATUS);
      chk("pll off", 32'h0, rd);
      wr(6'h3f, 8'h11);
      chk("unmapped wr", {30'h0, RESP_SLVERR}, {30'h0, resp});
      rdr(6'h3f);
      chk("unmapped rd", {30'h0, RESP_SLVERR}, {30'h0, resp});
   endtask
   task automatic measure(input int sh, input int per, input int ht, input int hi);
      int i, nt, ni;
      logic prev;
      i = 0;
      nt = 0;
      ni = 0;
      do begin
         prev = gate[sh+1];
         @(posedge clk_sys);
         i++;
      end while (!(prev === 1'b0 && gate[sh+1] === 1'b1) && i < 100);
      for (i = 0; i < per; i++) begin
         nt += int'(gate[sh+1] === 1'b1);
         ni += int'(gate[sh] === 1'b1);
         @(posedge clk_sys);
      end
      chk("next rise", 32'h1, {31'h0, gate[sh+1]});
      chk("true high", 32'(ht), 32'(nt));
      chk("inv high", 32'(hi), 32'(ni));
   endtask
   task automatic t_pwm;
      wr(IDX_TOP, 8'h09);
      wr(IDX_CMP_A, 8'h04);
      wr(IDX_CTRL_A, 8'h42);
      wr(IDX_CTRL_B, 8'h01);
      chk("oe", 32'hc, {28'h0, pin_oe});
      measure(2, 10, 3, 5);
      wr(IDX_CMP_A, 8'h06);
      rdr(IDX_CMP_A);
      chk("cmp held", 32'h6, rd);
      repeat (20) @(posedge clk_sys);
      measure(2, 10, 5, 3);
      rdr(IDX_FLAGS);
      chk("flags", 32'h5, rd & 32'h5);
      wr(IDX_INT_EN, 8'h85);
      @(posedge clk_sys);
      chk("irq on", 32'h1, {31'h0, irq_request});
      wr(IDX_CTRL_B, 8'h00);
      wr(IDX_FLAGS, 8'h07);
      rdr(IDX_FLAGS);
      chk("flags clr", 32'h0, rd);
      chk("irq off", 32'h0, {31'h0, irq_request});
      wr(IDX_COUNT, 8'h06);
      rdr(IDX_COUNT);
      chk("count", 32'h6, rd);
      repeat (4) @(posedge clk_sys);
      rdr(IDX_FLAGS);
      chk("no sw match", 32'h0, rd);
      chk("shoot", 32'h0, {31'h0, shoot});
   endtask
   task automatic t_modes;
      int i;
      i = 0;
      pll_sys_source <= 1'b1;
      rdr(IDX_PLL_STATUS);
      chk("pll forced", 32'h2, rd & 32'h2);
      do begin
         rdr(IDX_PLL_STATUS);
         i++;
      end while (rd[0] !== 1'b1 && i < 3000);
      wr(IDX_PLL_STATUS, 8'h04);
      rdr(IDX_PLL_STATUS);
      chk("async on", 32'h7, rd);
      wr(IDX_CTRL_A, 8'he3);
      chk("oe modes", 32'ha, {28'h0, pin_oe});
      wr(IDX_CMP_A, 8'h00);
      wr(IDX_CMP_B, 8'h03);
      wr(IDX_COUNT, 8'h01);
      rdr(IDX_COUNT);
      chk("count async", 32'h1, rd);
      // Clear on top, prescaler reset, source divided by two
      wr(IDX_CTRL_B, 8'hc2);
      repeat (80) @(posedge clk_sys);
      chk("static a", 32'h8, {28'h0, gate} & 32'hc);
      measure(0, 40, 8, 0);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      t_pll;
      t_pwm;
      t_modes;
      give_verdict;
   end
   initial begin
      #(25 * 40000);
      n_fail++;
      give_verdict;
   end
endmodule
